/* File: wetting_current_config_regs.sv */
/*
  Wetting current configuration bank: select, low and high level
  registers behind a classic Wishbone slave, plus the per-channel level
  decode and the continuous-mode scale-down after switch closure.
  Assumes switchClosed and continuousMode come from logic on clk, so
  they are used without synchronisers, and that the analog current
  sources follow levelOut.
*/
// The Wishbone register port is this design's own decision.
// Notes on behaviour
// - codes zero, one, two: off, 1 mA, 2 mA
// - code three 5 mA, code four 10 mA
// - codes five to seven all give 15 mA
// - low register fields drive channel pairs 0/1, 2/3
// - high fields drive channels 23, 22, pair 20/21
// - sink inputs at 10/15 mA drop to 2 mA
// - source inputs at 10/15 mA drop to 2 mA
// - disable bit set keeps configured high level
// - high register at index 1E, resets to zero
// - select bit zero source, one sink
`timescale 1ns/1ps

module wetting_current_config_regs
  import wetting_cfg_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic [DATA_W-1:0] dat_i,
  output logic [DATA_W-1:0] dat_o,
  output logic ack_o,
  // operating state from the detection logic
  input wire logic continuousMode,
  input wire logic [CHANNELS-1:0] switchClosed,
  // current source controls
  output logic [CHANNELS*FIELD_W-1:0] levelOut,
  output logic [NUM_SEL_CH-1:0] sinkSelect,
  output logic [CHANNELS-1:0] scaledDown
);

  // ***************************************************************
  // bus decode
  // ***************************************************************
  logic ack_reg;
  logic [DATA_W-1:0] readData_reg;
  logic [DATA_W-1:0] readData_next;
  logic [REG_W-1:0] select_reg;
  logic [REG_W-1:0] levelLow_reg;
  logic [REG_W-1:0] levelHigh_reg;
  logic [IDX_W-1:0] wordIdx;
  logic request;
  logic writeReq;
  logic readReq;

  // a new request is taken only while no ack is out, so a held
  // strobe cannot be answered on two cycles in a row
  assign request = cyc_i & stb_i & ~ack_reg;
  assign writeReq = request & we_i;
  assign readReq = request & ~we_i;
  assign wordIdx = adr_i[ADDR_W-1:2];

  // ack comes one edge after the request and lasts one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= request;
    end
  end

  assign ack_o = ack_reg;

  // ***************************************************************
  // byte-lane merge
  // ***************************************************************
  // only lanes 0 to 2 carry register bits; lane 3 is always dropped
  function automatic logic [REG_W-1:0] merge_lanes(
    input logic [REG_W-1:0] old,
    input logic [DATA_W-1:0] wdata,
    input logic [SEL_W-1:0] sel,
    input logic [REG_W-1:0] mask
  );
    logic [REG_W-1:0] res;
    res = old;
    for (int b = 0; b < REG_BYTES; b++) begin
      if (sel[b]) begin
        res[b*BYTE_W +: BYTE_W] = wdata[b*BYTE_W +: BYTE_W];
      end
    end
    return res & mask;
  endfunction

  // ***************************************************************
  // configuration registers
  // ***************************************************************
  // source or sink choice for the selectable channels
  always_ff @(posedge clk) begin
    if (srst) begin
      select_reg <= REG_RESET;
    end else if (writeReq && wordIdx == IDX_SELECT) begin
      select_reg <= merge_lanes(select_reg, dat_i, sel_i, SELECT_MASK);
    end
  end

  // low level register: codes for channels 0 to 11
  always_ff @(posedge clk) begin
    if (srst) begin
      levelLow_reg <= REG_RESET;
    end else if (writeReq && wordIdx == IDX_LOW) begin
      levelLow_reg <= merge_lanes(levelLow_reg, dat_i, sel_i, LOW_MASK);
    end
  end

  // high level register; the mask keeps bit 23 at zero
  always_ff @(posedge clk) begin
    if (srst) begin
      levelHigh_reg <= REG_RESET;
    end else if (writeReq && wordIdx == IDX_HIGH) begin
      levelHigh_reg <= merge_lanes(levelHigh_reg, dat_i, sel_i,
                                   HIGH_MASK);
    end
  end

  // ***************************************************************
  // read path
  // ***************************************************************
  // unmapped words answer with zero so software never sees stale data
  always_comb begin
    readData_next = READ_ZERO;
    unique case (wordIdx)
      IDX_SELECT: readData_next = {{(DATA_W-REG_W){1'b0}}, select_reg};
      IDX_LOW: readData_next = {{(DATA_W-REG_W){1'b0}}, levelLow_reg};
      IDX_HIGH: readData_next = {{(DATA_W-REG_W){1'b0}}, levelHigh_reg};
      IDX_SCALED: readData_next = {{(DATA_W-CHANNELS){1'b0}}, scaledDown};
      default: readData_next = READ_ZERO;
    endcase
  end

  // data is captured with the request and held until the next read
  always_ff @(posedge clk) begin
    if (srst) begin
      readData_reg <= READ_ZERO;
    end else if (readReq) begin
      readData_reg <= readData_next;
    end
  end

  assign dat_o = readData_reg;

  // ***************************************************************
  // level decode and scale-down
  // ***************************************************************
  logic [2*REG_W-1:0] fieldBits;
  level_t cfgLevel [CHANNELS];
  level_t level_next [CHANNELS];
  level_t level_reg [CHANNELS];
  logic [CHANNELS-1:0] scaled_next;
  logic [CHANNELS-1:0] scaled_reg;

  assign fieldBits = {levelHigh_reg, levelLow_reg};

  // channels above the selectable ones are taken as sourcing inputs
  always_comb begin
    for (int ch = 0; ch < CHANNELS; ch++) begin
      logic isSink;
      logic scaleOff;
      isSink = 1'b0;
      scaleOff = 1'b0;
      cfgLevel[ch] = decode_level(
        fieldBits[CH_FIELD_LSB[ch] +: FIELD_W]);
      if (ch < NUM_SEL_CH) begin
        isSink = select_reg[ch];
      end
      scaleOff = isSink ? levelHigh_reg[SINK_DIS_BIT]
                        : levelHigh_reg[SOURCE_DIS_BIT];
      scaled_next[ch] = continuousMode && switchClosed[ch] && !scaleOff &&
                        (cfgLevel[ch] == LEVEL_10MA ||
                         cfgLevel[ch] == LEVEL_15MA);
      level_next[ch] = scaled_next[ch] ? LEVEL_2MA : cfgLevel[ch];
    end
  end

  // one register stage so the current sources never see decode glitches
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        level_reg[ch] <= LEVEL_OFF;
      end
      scaled_reg <= '0;
    end else begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        level_reg[ch] <= level_next[ch];
      end
      scaled_reg <= scaled_next;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // flatten the level array, channel 0 in the low bits
  always_comb begin
    for (int ch = 0; ch < CHANNELS; ch++) begin
      levelOut[ch*FIELD_W +: FIELD_W] = level_reg[ch];
    end
  end

  assign sinkSelect = select_reg[NUM_SEL_CH-1:0];
  assign scaledDown = scaled_reg;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_ack_one_pulse: assert property (
    request |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse after request");

  a_reset_clears_high: assert property (
    $fell(srst) |-> levelHigh_reg == REG_RESET &&
                    levelLow_reg == REG_RESET)
    else $error("config not zero after reset");

  a_high_write_masked: assert property (
    writeReq && wordIdx == IDX_HIGH && sel_i == SEL_ALL |=>
      levelHigh_reg == ($past(dat_i[REG_W-1:0]) & HIGH_MASK) &&
      levelHigh_reg[RESERVED_LSB] == 1'b0)
    else $error("high register write wrong");

  a_high_read_reserved: assert property (
    readReq && wordIdx == IDX_HIGH |=>
      dat_o[DATA_W-1:RESERVED_LSB] == '0 &&
      dat_o[RESERVED_LSB-1:0] == $past(levelHigh_reg[RESERVED_LSB-1:0]))
    else $error("high register read wrong");

  a_low_pair_1ma: assert property (
    !continuousMode && levelLow_reg[2:0] == CODE_1MA |=>
      level_reg[0] == LEVEL_1MA && level_reg[1] == LEVEL_1MA)
    else $error("channel 0/1 not at 1 mA");

  a_pair23_2ma: assert property (
    !continuousMode && levelLow_reg[5:3] == CODE_2MA |=>
      level_reg[2] == LEVEL_2MA && level_reg[3] == LEVEL_2MA)
    else $error("channel 2/3 not at 2 mA");

  a_ch23_10ma: assert property (
    !continuousMode && levelHigh_reg[20:18] == CODE_10MA |=>
      level_reg[23] == LEVEL_10MA)
    else $error("channel 23 not at 10 mA");

  a_ch22_top: assert property (
    !continuousMode && levelHigh_reg[17:15] >= CODE_15MA |=>
      level_reg[22] == LEVEL_15MA)
    else $error("channel 22 not at 15 mA");

  a_pair2021_5ma: assert property (
    !continuousMode && levelHigh_reg[14:12] == CODE_5MA |=>
      level_reg[20] == LEVEL_5MA && level_reg[21] == LEVEL_5MA)
    else $error("channel 20/21 not at 5 mA");

  a_sink_scale: assert property (
    continuousMode && switchClosed[0] && select_reg[0] &&
    !levelHigh_reg[SINK_DIS_BIT] && levelLow_reg[2:0] == CODE_10MA |=>
      level_reg[0] == LEVEL_2MA && scaledDown[0])
    else $error("sinking channel 0 not scaled to 2 mA");

  a_source_scale: assert property (
    continuousMode && switchClosed[1] && !select_reg[1] &&
    !levelHigh_reg[SOURCE_DIS_BIT] && levelLow_reg[2:0] >= CODE_15MA |=>
      level_reg[1] == LEVEL_2MA)
    else $error("sourcing channel 1 not scaled to 2 mA");

  a_disable_keeps: assert property (
    continuousMode && switchClosed[23] &&
    levelHigh_reg[SOURCE_DIS_BIT] && levelHigh_reg[20:18] == CODE_10MA |=>
      level_reg[23] == LEVEL_10MA && !scaledDown[23])
    else $error("disabled scale-down still reduced channel 23");

  a_select_group: assert property (
    continuousMode && switchClosed[2] && select_reg[2] &&
    levelHigh_reg[SINK_DIS_BIT] && !levelHigh_reg[SOURCE_DIS_BIT] &&
    levelLow_reg[5:3] == CODE_10MA |=>
      level_reg[2] == LEVEL_10MA)
    else $error("sink channel used the source disable bit");

  // the ack must only ever follow a request that was taken
  a_ack_needs_req: assert property (
    !request |=> !ack_o)
    else $error("ack without a taken request");

  a_low_write: assert property (
    writeReq && wordIdx == IDX_LOW && sel_i == SEL_ALL |=>
      levelLow_reg == $past(dat_i[REG_W-1:0]))
    else $error("low register write wrong");

  a_pair01_off: assert property (
    !continuousMode && levelLow_reg[2:0] == CODE_OFF |=>
      level_reg[0] == LEVEL_OFF && level_reg[1] == LEVEL_OFF)
    else $error("channel 0/1 not off");

  a_pair01_2ma: assert property (
    !continuousMode && levelLow_reg[2:0] == CODE_2MA |=>
      level_reg[0] == LEVEL_2MA && level_reg[1] == LEVEL_2MA)
    else $error("channel 0/1 not at 2 mA");

  a_pair01_10ma: assert property (
    !continuousMode && levelLow_reg[2:0] == CODE_10MA |=>
      level_reg[0] == LEVEL_10MA && level_reg[1] == LEVEL_10MA)
    else $error("channel 0/1 not at 10 mA");

  a_pair23_5ma: assert property (
    !continuousMode && levelLow_reg[5:3] == CODE_5MA |=>
      level_reg[2] == LEVEL_5MA && level_reg[3] == LEVEL_5MA)
    else $error("channel 2/3 not at 5 mA");

  a_pair23_top: assert property (
    !continuousMode && levelLow_reg[5:3] >= CODE_15MA |=>
      level_reg[2] == LEVEL_15MA && level_reg[3] == LEVEL_15MA)
    else $error("channel 2/3 not at 15 mA");

  a_pair2021_top: assert property (
    !continuousMode && levelHigh_reg[14:12] >= CODE_15MA |=>
      level_reg[20] == LEVEL_15MA && level_reg[21] == LEVEL_15MA)
    else $error("channel 20/21 not at 15 mA");

  // scale-down is a continuous-mode feature only
  a_idle_no_scale: assert property (
    !continuousMode |=> scaledDown == '0)
    else $error("scale-down outside continuous mode");

  a_reserved_zero: assert property (
    levelHigh_reg[RESERVED_LSB] == 1'b0)
    else $error("reserved high bit set");

  a_select_upper: assert property (
    select_reg[REG_W-1:NUM_SEL_CH] == '0)
    else $error("select bits above channel 9 set");

endmodule

/* File: wetting_cfg_pkg.sv */
/*
  Constants, field layout and level type for the wetting current
  configuration bank.
  Assumes a 32-bit classic Wishbone slave with word-aligned registers;
  each register index is one word, byte address is four times the index.
*/
package wetting_cfg_pkg;

  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int NUM_CH = 24;
  localparam int NUM_SEL_CH = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 24;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int SEL_W = 4;
  localparam int BYTE_W = 8;
  localparam int FIELD_W = 3;
  localparam int REG_BYTES = 3;

  // ***************************************************************
  // register indices (byte address = index * 4)
  // ***************************************************************
  localparam logic [IDX_W-1:0] IDX_SELECT = 6'h1C;
  localparam logic [IDX_W-1:0] IDX_LOW = 6'h1D;
  localparam logic [IDX_W-1:0] IDX_HIGH = 6'h1E;
  localparam logic [IDX_W-1:0] IDX_SCALED = 6'h3F;

  // ***************************************************************
  // writable masks and reset values
  // ***************************************************************
  localparam logic [REG_W-1:0] SELECT_MASK = 24'h0003FF;
  localparam logic [REG_W-1:0] LOW_MASK = 24'hFFFFFF;
  localparam logic [REG_W-1:0] HIGH_MASK = 24'h7FFFFF;
  localparam logic [REG_W-1:0] REG_RESET = 24'h000000;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;
  localparam logic [SEL_W-1:0] SEL_ALL = 4'hF;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int SINK_DIS_BIT = 22;
  localparam int SOURCE_DIS_BIT = 21;
  localparam int RESERVED_LSB = 23;
  // lsb of each channel's level code in the 48-bit {high, low} pair
  localparam int CH_FIELD_LSB [NUM_CH] = '{
    0, 0, 3, 3, 6, 9, 12, 12, 15, 15, 18, 21,
    24, 24, 27, 27, 30, 30, 33, 33, 36, 36, 39, 42};

  // ***************************************************************
  // level codes and decoded levels
  // ***************************************************************
  localparam logic [FIELD_W-1:0] CODE_OFF = 3'h0;
  localparam logic [FIELD_W-1:0] CODE_1MA = 3'h1;
  localparam logic [FIELD_W-1:0] CODE_2MA = 3'h2;
  localparam logic [FIELD_W-1:0] CODE_5MA = 3'h3;
  localparam logic [FIELD_W-1:0] CODE_10MA = 3'h4;
  localparam logic [FIELD_W-1:0] CODE_15MA = 3'h5;

  typedef enum logic [FIELD_W-1:0] {
    LEVEL_OFF, LEVEL_1MA, LEVEL_2MA, LEVEL_5MA, LEVEL_10MA, LEVEL_15MA
  } level_t;

  // codes five to seven all fold onto the top level
  function automatic level_t decode_level(input logic [FIELD_W-1:0] code);
    level_t lvl;
    lvl = LEVEL_15MA;
    unique case (code)
      CODE_OFF: lvl = LEVEL_OFF;
      CODE_1MA: lvl = LEVEL_1MA;
      CODE_2MA: lvl = LEVEL_2MA;
      CODE_5MA: lvl = LEVEL_5MA;
      CODE_10MA: lvl = LEVEL_10MA;
      default: lvl = LEVEL_15MA;
    endcase
    return lvl;
  endfunction

endpackage

/* File: tb_wetting_current_config_regs.sv */
/*
  Self-checking bench for the wetting current configuration bank.
  Assumes the bank answers a classic Wishbone cycle with a one-cycle
  ack and that level outputs settle one edge after any change.
*/
`timescale 1ns/1ps

module tb_wetting_current_config_regs
  import wetting_cfg_pkg::*;
;
  // ***************************************************************
  // signals
  // ***************************************************************
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADDR_W-1:0] adr = 8'h00;
  logic [SEL_W-1:0] sel = 4'h0;
  logic [DATA_W-1:0] dat = 32'h00000000;
  logic [DATA_W-1:0] datOut;
  logic ack;
  logic contMode = 1'b0;
  logic [NUM_CH-1:0] closed = 24'h000000;
  logic [NUM_CH*FIELD_W-1:0] levelOut;
  logic [NUM_SEL_CH-1:0] sinkSel;
  logic [NUM_CH-1:0] scaled;
  logic [DATA_W-1:0] rd;
  int n_fail = 0;
  int total_checks = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  wetting_current_config_regs #(.CHANNELS(NUM_CH)) DUT (
    .clk(clk), .srst(srst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(datOut), .ack_o(ack),
    .continuousMode(contMode), .switchClosed(closed),
    .levelOut(levelOut), .sinkSelect(sinkSel), .scaledDown(scaled)
  );

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] seen,
                     input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic cycle; read data is taken at the ack edge only
  task automatic wb(input logic w, input logic [IDX_W-1:0] idx,
                    input logic [DATA_W-1:0] wd);
    int i;
    i = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= SEL_ALL;
    dat <= wd;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      n_fail++;
      conclude();
    end
    rd = datOut;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // let level logic see the change, then sample on an edge
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [DATA_W-1:0] lv(input int ch);
    return {29'h0, levelOut[ch*FIELD_W +: FIELD_W]};
  endfunction

  // folding of codes onto levels, kept apart from the design
  function automatic logic [DATA_W-1:0] expLv(input int code);
    return (code > 4) ? 32'h00000005 : code;
  endfunction

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset();
    wb(1'b0, IDX_HIGH, 32'h0);
    chk(rd, 32'h00000000);
    wb(1'b0, IDX_LOW, 32'h0);
    chk(rd, 32'h00000000);
    chk(levelOut[31:0], 32'h00000000);
    chk({8'h00, scaled}, 32'h00000000);
  endtask

  // every code into both low pair fields, two channels each
  task automatic t_decode();
    int c;
    for (c = 0; c < 8; c++) begin
      wb(1'b1, IDX_LOW, (7 - c) << 3 | c);
      settle();
      chk(lv(0), expLv(c));
      chk(lv(1), expLv(c));
      chk(lv(2), expLv(7 - c));
      chk(lv(3), expLv(7 - c));
    end
    wb(1'b0, IDX_LOW, 32'h0);
    chk(rd, 32'h00000007);
  endtask

  task automatic t_high();
    wb(1'b1, IDX_HIGH, 32'h0011E000);
    settle();
    chk(lv(23), 32'h00000004);
    chk(lv(22), 32'h00000003);
    chk(lv(21), 32'h00000005);
    chk(lv(20), 32'h00000005);
    chk(lv(19), 32'h00000000);
    wb(1'b1, IDX_HIGH, 32'hFFFFFFFF);
    wb(1'b0, IDX_HIGH, 32'h0);
    chk(rd, 32'h007FFFFF);
    wb(1'b1, IDX_HIGH, 32'h0);
    wb(1'b0, IDX_HIGH, 32'h0);
    chk(rd, 32'h00000000);
  endtask

  // ch0 sinks at 10 mA, ch2 sources at 15 mA, ch4 at 5 mA
  task automatic t_scale();
    wb(1'b1, IDX_SELECT, 32'h00000001);
    wb(1'b0, IDX_SELECT, 32'h0);
    chk(rd, 32'h00000001);
    wb(1'b1, IDX_LOW, 32'h000000EC);
    @(posedge clk);
    closed <= 24'h80001F;
    settle();
    chk(lv(0), 32'h00000004);
    @(posedge clk);
    contMode <= 1'b1;
    settle();
    chk(lv(0), 32'h00000002);
    chk(lv(2), 32'h00000002);
    chk(lv(4), 32'h00000003);
    chk({8'h00, scaled}, 32'h0000000F);
    wb(1'b0, IDX_SCALED, 32'h0);
    chk(rd, 32'h0000000F);
    wb(1'b1, IDX_HIGH, 32'h00400000);
    settle();
    chk(lv(0), 32'h00000004);
    chk(lv(2), 32'h00000002);
    wb(1'b1, IDX_HIGH, 32'h00300000);
    settle();
    chk(lv(0), 32'h00000002);
    chk(lv(3), 32'h00000005);
    chk(lv(23), 32'h00000004);
    @(posedge clk);
    closed <= 24'h000000;
    settle();
    chk(lv(1), 32'h00000004);
    chk({8'h00, scaled}, 32'h00000000);
  endtask

  // unmapped place answers, reads zero and keeps nothing
  task automatic t_unmapped();
    wb(1'b1, 6'h05, 32'hFFFFFFFF);
    wb(1'b0, 6'h05, 32'h0);
    chk(rd, 32'h00000000);
    wb(1'b0, IDX_LOW, 32'h0);
    chk(rd, 32'h000000EC);
  endtask

  // ch2 sinks with its group bit set and keeps 10 mA; 0, 1, 3 source
  task automatic t_group();
    wb(1'b1, IDX_SELECT, 32'h00000004);
    wb(1'b1, IDX_LOW, 32'h00000025);
    wb(1'b1, IDX_HIGH, 32'h00400000);
    @(posedge clk);
    closed <= 24'h00000F;
    settle();
    chk({22'h0, sinkSel}, 32'h00000004);
    chk(lv(0), 32'h00000002);
    chk(lv(1), 32'h00000002);
    chk(lv(2), 32'h00000004);
    chk(lv(3), 32'h00000002);
    chk({8'h00, scaled}, 32'h0000000B);
  endtask

  // a reset in mid-run must clear state that was written before it
  task automatic t_midreset();
    @(posedge clk);
    contMode <= 1'b0;
    closed <= 24'h000000;
    wb(1'b1, IDX_HIGH, 32'h00703000);
    settle();
    chk(lv(20), 32'h00000003);
    chk(lv(21), 32'h00000003);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    wb(1'b0, IDX_HIGH, 32'h0);
    chk(rd, 32'h00000000);
    wb(1'b0, IDX_LOW, 32'h0);
    chk(rd, 32'h00000000);
    wb(1'b0, IDX_SELECT, 32'h0);
    chk(rd, 32'h00000000);
    chk({22'h0, sinkSel}, 32'h00000000);
    chk(levelOut[31:0], 32'h00000000);
    chk(levelOut[63:32], 32'h00000000);
    chk({24'h0, levelOut[71:64]}, 32'h00000000);
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_decode();
    t_high();
    t_scale();
    t_unmapped();
    t_group();
    t_midreset();
    conclude();
  end

endmodule
